// *** hw/acqirq_defines.svh ***
// Purpose: Register offsets, field positions and reset values
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef ACQIRQ_DEFINES_SVH
`define ACQIRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ACQIRQ_OFS_STATUS   12'h000
`define ACQIRQ_OFS_ENABLE   12'h004
`define ACQIRQ_OFS_CLEAR    12'h008
`define ACQIRQ_OFS_CONTROL  12'h00C
`define ACQIRQ_OFS_RAW      12'h010

// ----------------------------------------------------------------------
// Event bit positions
// ----------------------------------------------------------------------
`define ACQIRQ_BIT_ACQ_RUN   0
`define ACQIRQ_BIT_ACQ_STOP  1
`define ACQIRQ_BIT_ACQ_DONE  2
`define ACQIRQ_BIT_IN_QTR    3
`define ACQIRQ_BIT_CONV      4
`define ACQIRQ_BIT_EOSCAN    5
`define ACQIRQ_BIT_EOINT     6
`define ACQIRQ_BIT_OUT_RUN   7
`define ACQIRQ_BIT_OUT_DONE  8
`define ACQIRQ_BIT_OUT_QTR   9
`define ACQIRQ_BIT_HIGH_CH   10
`define ACQIRQ_BIT_RETX      11
`define ACQIRQ_BIT_EXT       12
`define ACQIRQ_NUM_EVENTS    13

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define ACQIRQ_CTL_EXT_FALL  0
`define ACQIRQ_RST_ENABLE    13'h0000
`define ACQIRQ_RST_CONTROL   1'b0

`endif

// *** hw/acqirq_pkg.sv ***
// Purpose: Types shared by the interrupt source block
// Assumes: Constants come from acqirq_defines.svh
// Notes:   Types only
`include "acqirq_defines.svh"

package acqirq_pkg;

   typedef logic [`ACQIRQ_NUM_EVENTS-1:0] acqirq_vec_type;

   typedef enum logic [1:0] {
      ACQIRQ_IDLE   = 2'b01,
      ACQIRQ_ACCESS = 2'b10
   } acqirq_bus_type;

endpackage : acqirq_pkg

// *** hw/acqirq_sync_edge.sv ***
// Purpose: Two-flop synchroniser with rise and fall detection
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   First flop is read only by the second
`timescale 1ns/100ps
`default_nettype none

module acqirq_sync_edge #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] async,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] last;
   } acqirq_sync_type;

   acqirq_sync_type state_reg;
   acqirq_sync_type state_next;

   always_comb begin
      state_next      = state_reg;
      state_next.meta = async;
      state_next.sync = state_reg.meta;
      state_next.last = state_reg.sync;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign level = state_reg.sync;
   assign rise  = state_reg.sync & ~state_reg.last;
   assign fall  = ~state_reg.sync & state_reg.last;

endmodule : acqirq_sync_edge

`default_nettype wire

// *** hw/acqirq_top.sv ***
// Purpose: Interrupt sources of the acquisition board, APB registers
// Assumes: Event inputs are asynchronous levels or pulses from pins
// Notes:   One active-low interrupt line to the host
//
// Contract
// - Request host interrupt on bus line A
// - Flag while acquisition sequence runs
// - Flag on external acquisition stop trigger
// - Flag when acquisition sequence finishes
// - Flag when input FIFO quarter full
// - Flag after each single conversion
// - Flag after last scan channel converted
// - Flag after each inter-scan interval expires
// - Flag while output waveform circuitry runs
// - Flag when output sequence finishes
// - Flag when output FIFO quarter empty
// - Flag on highest output channel update
// - Flag at waveform end in retransmit mode
// - External interrupt is edge, not level
// - Software picks rising or falling edge
`timescale 1ns/100ps
`default_nettype none
`include "acqirq_defines.svh"

module acqirq_top (
   input  wire logic        clk,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Acquisition sequencer conditions
   input  wire logic        acqRunning,
   input  wire logic        acqStopTrigger,
   input  wire logic        acqComplete,
   input  wire logic        inFifoQuarter,
   input  wire logic        convDone,
   input  wire logic        scanDone,
   input  wire logic        intervalDone,
   // Waveform output conditions
   input  wire logic        outRunning,
   input  wire logic        outComplete,
   input  wire logic        outFifoQuarter,
   input  wire logic        highChanUpdate,
   input  wire logic        retransmitMode,
   input  wire logic        retransmitEnd,
   // External interrupt pin
   input  wire logic        extIrqPin,
   // Host interrupt line A, active low
   output logic             irqLineA_n
);

   localparam int N = `ACQIRQ_NUM_EVENTS;

   // ----------------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------------
   localparam int NIN = 14;

   logic [NIN-1:0] rawIn;
   logic [NIN-1:0] lvl;
   logic [NIN-1:0] rise;
   logic [NIN-1:0] fall;

   assign rawIn = {extIrqPin, retransmitEnd, retransmitMode, highChanUpdate,
                   outFifoQuarter, outComplete, outRunning, intervalDone,
                   scanDone, convDone, inFifoQuarter, acqComplete,
                   acqStopTrigger, acqRunning};

   acqirq_sync_edge #(
      .WIDTH (NIN)
   ) u_sync (
      .clk   (clk),
      .nrst  (nrst),
      .async (rawIn),
      .level (lvl),
      .rise  (rise),
      .fall  (fall)
   );

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      acqirq_pkg::acqirq_vec_type status;
      acqirq_pkg::acqirq_vec_type enable;
      logic                       extFall;
      acqirq_pkg::acqirq_bus_type bus;
      logic [31:0]                rdata;
      logic                       ready;
      logic                       slverr;
      logic                       irqN;
   } acqirq_state_type;

   acqirq_state_type state_reg;
   acqirq_state_type state_next;

   acqirq_pkg::acqirq_vec_type events;
   acqirq_pkg::acqirq_vec_type clearMask;
   logic                       apbWrite;
   logic                       apbRead;
   logic                       addrOk;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `ACQIRQ_OFS_STATUS) || (a == `ACQIRQ_OFS_ENABLE) ||
                  (a == `ACQIRQ_OFS_CLEAR) || (a == `ACQIRQ_OFS_CONTROL) ||
                  (a == `ACQIRQ_OFS_RAW);
   endfunction : is_mapped

   // ----------------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------------
   always_comb begin
      events = '0;
      events[`ACQIRQ_BIT_ACQ_RUN]  = lvl[0];
      events[`ACQIRQ_BIT_ACQ_STOP] = rise[1];
      events[`ACQIRQ_BIT_ACQ_DONE] = rise[2];
      events[`ACQIRQ_BIT_IN_QTR]   = rise[3];
      events[`ACQIRQ_BIT_CONV]     = rise[4];
      events[`ACQIRQ_BIT_EOSCAN]   = rise[5];
      events[`ACQIRQ_BIT_EOINT]    = rise[6];
      events[`ACQIRQ_BIT_OUT_RUN]  = lvl[7];
      events[`ACQIRQ_BIT_OUT_DONE] = rise[8];
      events[`ACQIRQ_BIT_OUT_QTR]  = rise[9];
      events[`ACQIRQ_BIT_HIGH_CH]  = rise[10];
      events[`ACQIRQ_BIT_RETX]     = rise[12] & lvl[11];
      events[`ACQIRQ_BIT_EXT]      = state_reg.extFall ? fall[13]
                                                       : rise[13];
   end

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   assign addrOk   = is_mapped(paddr);
   assign apbWrite = psel & penable & pwrite & state_reg.ready;
   assign apbRead  = psel & penable & ~pwrite & state_reg.ready;

   always_comb begin
      clearMask = '0;
      if (apbWrite && paddr == `ACQIRQ_OFS_CLEAR) begin
         clearMask = pwdata[N-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      state_next        = state_reg;
      state_next.status = (state_reg.status & ~clearMask) | events;
      state_next.ready  = 1'b0;
      state_next.slverr = 1'b0;
      unique case (state_reg.bus)
         acqirq_pkg::ACQIRQ_IDLE: begin
            if (psel && !penable) begin
               state_next.bus    = acqirq_pkg::ACQIRQ_ACCESS;
               state_next.ready  = 1'b1;
               state_next.slverr = ~addrOk;
               state_next.rdata  = '0;
               if (!pwrite) begin
                  unique case (paddr)
                     `ACQIRQ_OFS_STATUS:
                        state_next.rdata[N-1:0] = state_reg.status;
                     `ACQIRQ_OFS_ENABLE:
                        state_next.rdata[N-1:0] = state_reg.enable;
                     `ACQIRQ_OFS_CONTROL:
                        state_next.rdata[0] = state_reg.extFall;
                     `ACQIRQ_OFS_RAW:
                        state_next.rdata[NIN-1:0] = lvl;
                     default:
                        state_next.rdata = '0;
                  endcase
               end
            end
         end
         acqirq_pkg::ACQIRQ_ACCESS: begin
            state_next.bus = acqirq_pkg::ACQIRQ_IDLE;
            if (apbWrite && paddr == `ACQIRQ_OFS_ENABLE) begin
               state_next.enable = pwdata[N-1:0];
            end
            if (apbWrite && paddr == `ACQIRQ_OFS_CONTROL) begin
               state_next.extFall = pwdata[`ACQIRQ_CTL_EXT_FALL];
            end
         end
         default: begin
            state_next.bus = acqirq_pkg::ACQIRQ_IDLE;
         end
      endcase
      state_next.irqN = ~|(state_next.status & state_next.enable);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg         <= '0;
         state_reg.bus     <= acqirq_pkg::ACQIRQ_IDLE;
         state_reg.enable  <= `ACQIRQ_RST_ENABLE;
         state_reg.extFall <= `ACQIRQ_RST_CONTROL;
         state_reg.irqN    <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign prdata     = state_reg.rdata;
   assign pready     = state_reg.ready;
   assign pslverr    = state_reg.slverr;
   assign irqLineA_n = state_reg.irqN;

   logic unusedApb;
   assign unusedApb = ^{pwdata[31:N], apbRead};

endmodule : acqirq_top

`default_nettype wire

// *** verification/acqirq_host_model.sv ***
// Purpose: Host interrupt controller seen from line A
// Assumes: Line is active low, registered by the block
// Notes:   Counts interrupts taken by the host
`timescale 1ns/100ps
`default_nettype none
module acqirq_host_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       irqLineA_n,
   output logic      [7:0] irqTaken
);
   logic lineReg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lineReg  <= 1'b1;
         irqTaken <= 8'h00;
      end else begin
         lineReg <= irqLineA_n;
         if (lineReg && !irqLineA_n) begin
            irqTaken <= irqTaken + 8'h01;
         end
      end
   end
endmodule : acqirq_host_model
`default_nettype wire

// *** verification/acqirq_properties.sv ***
// Purpose: Port checks of the interrupt source block
// Assumes: Sees only top ports
// Notes:   Enable copy kept from APB writes
`timescale 1ns/100ps
`default_nettype none
module acqirq_properties (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        acqRunning,
   input wire logic        outRunning,
   input wire logic        irqLineA_n
);
   logic [12:0] enReg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         enReg <= 13'h0000;
      end else if (psel && penable && pready && pwrite && paddr == 12'h004) begin
         enReg <= pwdata[12:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_ans; psel && !penable |=> pready; endproperty
   property p_one; pready |=> !pready; endproperty
   property p_idle; !psel |=> !pready; endproperty
   property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
   property p_rel; $rose(irqLineA_n) |-> $past(psel && penable && pwrite);
   endproperty
   property p_gate; $fell(irqLineA_n) |-> enReg != 13'h0000; endproperty
   property p_run; (acqRunning && enReg[0])[*4] |-> !irqLineA_n; endproperty
   property p_out; (outRunning && enReg[7])[*4] |-> !irqLineA_n; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   a_one: assert property (p_one) else $error("long ready");
   a_idle: assert property (p_idle) else $error("stray ready");
   a_err: assert property (p_err) else $error("bad error");
   a_rel: assert property (p_rel) else $error("line freed");
   a_gate: assert property (p_gate) else $error("unmasked");
   a_run: assert property (p_run) else $error("run lost");
   a_out: assert property (p_out) else $error("out lost");
   c_err: cover property (pslverr);
   c_irq: cover property ($fell(irqLineA_n));
   c_rel: cover property ($rose(irqLineA_n));
endmodule : acqirq_properties
`default_nettype wire

// *** verification/acq_board_interrupt_sources_tb_top.sv ***
// Purpose: Self-checking bench of the interrupt source block
// Assumes: APB answer in access phase
// Notes:   Events pulsed 4 cycles high and 4 low; retransmit mode, ext pin and acq run also held as levels
`timescale 1ns/100ps
`default_nettype none
module acq_board_interrupt_sources_tb_top;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irqLineA_n, er;
   logic [13:0] evIn = 14'h0000;
   logic [7:0]  irqTaken;
   int          mismatches = 0;
   int          num_checks = 0;
   always #4 clk = ~clk;
   acqirq_top dut_u (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acqRunning(evIn[0]), .acqStopTrigger(evIn[1]),
      .acqComplete(evIn[2]), .inFifoQuarter(evIn[3]), .convDone(evIn[4]),
      .scanDone(evIn[5]), .intervalDone(evIn[6]), .outRunning(evIn[7]),
      .outComplete(evIn[8]), .outFifoQuarter(evIn[9]),
      .highChanUpdate(evIn[10]), .retransmitMode(evIn[11]),
      .retransmitEnd(evIn[12]), .extIrqPin(evIn[13]),
      .irqLineA_n(irqLineA_n));
   acqirq_host_model host_u (.clk(clk), .nrst(nrst),
      .irqLineA_n(irqLineA_n), .irqTaken(irqTaken));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic pulse(input int i);
      evIn[i] <= 1'b1;
      repeat (4) @(posedge clk);
      evIn[i] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse
   task automatic extStep(input logic v, input logic [31:0] exp);
      evIn[13] <= v;
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, exp);
      apb(1'b1, 12'h008, 32'h0000_1FFF);
   endtask : extStep
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk(32'(irqLineA_n), 32'h0000_0001);
      for (int a = 0; a < 24; a += 4) begin
         apb(1'b0, a[11:0], 32'h0000_0000);
         chk(rd, 32'h0000_0000);
         chk(32'(er), 32'(a == 20));
      end
      apb(1'b1, 12'h004, 32'h0000_1FFF);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd, 32'h0000_1FFF);
      for (int i = 0; i < 11; i++) begin
         pulse(i);
         apb(1'b0, 12'h000, 32'h0000_0000);
         chk(rd, 32'h1 << i);
         chk(32'(irqLineA_n), 32'h0000_0000);
         apb(1'b1, 12'h008, 32'h1 << i);
         chk(32'(irqLineA_n), 32'h0000_0001);
      end
      pulse(12);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      evIn[11] <= 1'b1;
      @(posedge clk);
      pulse(12);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0800);
      apb(1'b1, 12'h008, 32'h0000_0800);
      extStep(1'b1, 32'h0000_1000);
      extStep(1'b1, 32'h0000_0000);
      extStep(1'b0, 32'h0000_0000);
      apb(1'b1, 12'h00C, 32'h0000_0001);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      extStep(1'b1, 32'h0000_0000);
      extStep(1'b0, 32'h0000_1000);
      apb(1'b1, 12'h004, 32'h0000_0002);
      pulse(1);
      pulse(2);
      apb(1'b1, 12'h008, 32'h0000_0002);
      chk(32'(irqLineA_n), 32'h0000_0001);
      apb(1'b1, 12'h004, 32'h0000_0004);
      chk(32'(irqLineA_n), 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0004);
      chk(32'(irqLineA_n), 32'h0000_0001);
      chk(32'(irqTaken), 32'h0000_0010);
      apb(1'b1, 12'h004, 32'h0000_0001);
      evIn[0] <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b1, 12'h008, 32'h0000_0001);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      chk(32'(irqLineA_n), 32'h0000_0000);
      evIn[0] <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b1, 12'h008, 32'h0000_0001);
      chk(32'(irqLineA_n), 32'h0000_0001);
      test_done();
   end
endmodule : acq_board_interrupt_sources_tb_top
bind acqirq_top acqirq_properties chk_u (.clk(clk), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .acqRunning(acqRunning), .outRunning(outRunning),
   .irqLineA_n(irqLineA_n));
`default_nettype wire
